//--- design/ifsb_defs.vh
// Register offsets, field masks and reset values of the flag bank
`ifndef IFSB_DEFS_VH
`define IFSB_DEFS_VH

// APB byte offsets
`define IFSB_OFF_FLAGS0   12'h000
`define IFSB_OFF_FLAGS1   12'h004
`define IFSB_OFF_ENABLE0  12'h008
`define IFSB_OFF_ENABLE1  12'h00c
`define IFSB_OFF_POLARITY 12'h010

// Implemented bit masks
`define IFSB_MASK0        16'hbfef
`define IFSB_MASK1        16'hfa1f
`define IFSB_POL_MASK     16'h0007

// Reset values
`define IFSB_FLAGS_RST    16'h0000
`define IFSB_ENABLE_RST   16'h0000
`define IFSB_POL_RST      16'h0000

// Bit positions, first register
`define IFSB_B0_NVM       15
`define IFSB_B0_ADC       13
`define IFSB_B0_UA_TX     12
`define IFSB_B0_UA_RX     11
`define IFSB_B0_SPI_EV    10
`define IFSB_B0_SPI_FLT   9
`define IFSB_B0_TMR_C     8
`define IFSB_B0_TMR_B     7
`define IFSB_B0_OC_B      6
`define IFSB_B0_IC_B      5
`define IFSB_B0_TMR_A     3
`define IFSB_B0_OC_A      2
`define IFSB_B0_IC_A      1
`define IFSB_B0_EXT_A     0

// Bit positions, second register
`define IFSB_B1_UB_TX     15
`define IFSB_B1_UB_RX     14
`define IFSB_B1_EXT_C     13
`define IFSB_B1_TMR_E     12
`define IFSB_B1_TMR_D     11
`define IFSB_B1_OC_C      9
`define IFSB_B1_EXT_B     4
`define IFSB_B1_PIN_CHG   3
`define IFSB_B1_CMP       2
`define IFSB_B1_I2C_MST   1
`define IFSB_B1_I2C_SLV   0

`endif

//--- design/ifsb_flag_bank.v
// Interrupt flag status bank with APB access and external edge detect
//
// What this block does
// - A flag stays one from its source request until software writes it to zero.
// - Hardware sets flags, software reads and writes; reset clears all.
// - Unimplemented bits read zero and ignore writes.
// - First register bit 15 records the memory controller request.
// - First register bit 13 records A/D conversion complete.
// - First register bits 12 and 11: first UART transmit, receive.
// - First register bits 10 and 9: first SPI event, fault.
// - First register bits 8, 7, 3: timers three, two, one.
// - First register bits 6 and 2: output compare two, one.
// - First register bits 5 and 1: input capture two, one.
// - First register bit 0 records external interrupt zero.
// - Second register bits 15 and 14: second UART transmit, receive.
// - Second register bit 13 records external interrupt two.
// - Second register bits 12 and 11: timers five and four.
// - Second register bit 9 records output compare three.
// - Second register bit 4 records external interrupt one.
// - Second register bit 3 records pin change notification.
// - Second register bit 2 records the comparator request.
// - Second register bits 1 and 0: first I2C master, slave.
// - Enabled flags alone reach the CPU; flags record regardless.
// - External pins: rising edge if polarity zero, falling if one.
`timescale 1ns/10ps
`include "ifsb_defs.vh"

module ifsb_flag_bank (
  // Clock and reset
  input  wire        clk,
  input  wire        srst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  // Peripheral request pulses, first register sources
  input  wire        nvm_req,
  input  wire        adc_done_req,
  input  wire        uart_a_tx_req,
  input  wire        uart_a_rx_req,
  input  wire        spi_a_event_req,
  input  wire        spi_a_fault_req,
  input  wire        timer_a_req,
  input  wire        timer_b_req,
  input  wire        timer_c_req,
  input  wire        outcmp_a_req,
  input  wire        outcmp_b_req,
  input  wire        incap_a_req,
  input  wire        incap_b_req,
  // Peripheral request pulses, second register sources
  input  wire        uart_b_tx_req,
  input  wire        uart_b_rx_req,
  input  wire        timer_d_req,
  input  wire        timer_e_req,
  input  wire        outcmp_c_req,
  input  wire        pin_change_req,
  input  wire        comparator_req,
  input  wire        i2c_a_master_req,
  input  wire        i2c_a_slave_req,
  // External interrupt pins, index 0 to 2
  input  wire [2:0]  ext_irq_pin,
  // Flags and CPU requests
  output reg  [15:0] irq_flags_0,
  output reg  [15:0] irq_flags_1,
  output reg  [15:0] cpu_req_0,
  output reg  [15:0] cpu_req_1
);

  reg  [15:0] irq_enable_0;
  reg  [15:0] irq_enable_1;
  reg  [15:0] ext_irq_polarity;
  reg  [2:0]  ext_pin_prev;
  wire [2:0]  ext_edge;
  reg  [15:0] hw_set_0;
  reg  [15:0] hw_set_1;
  reg  [15:0] next_flags_0;
  reg  [15:0] next_flags_1;
  reg  [15:0] next_enable_0;
  reg  [15:0] next_enable_1;
  reg  [15:0] next_polarity;
  reg  [31:0] next_prdata;
  wire        bus_access;
  wire        wr_access;
  wire        rd_setup;
  wire [15:0] wr_lanes;
  wire        wr_flags_0;
  wire        wr_flags_1;
  wire        wr_enable_0;
  wire        wr_enable_1;
  wire        wr_polarity;
  genvar      g;

  // Positions that hardware may set; every implemented flag is settable
  localparam [15:0] hw_settable_0 = `IFSB_MASK0;
  localparam [15:0] hw_settable_1 = `IFSB_MASK1;

  // Merge the low two byte strobes into a 16-bit write mask
  function [15:0] lane_mask;
    input [3:0] strb;
    begin
      lane_mask = {{8{strb[1]}}, {8{strb[0]}}};
    end
  endfunction

  // True when the bus address selects the given register offset
  function addr_hit;
    input [11:0] addr;
    input [11:0] offset;
    begin
      addr_hit = (addr == offset);
    end
  endfunction

  // Single-cycle answer; unmapped addresses report an error
  function is_mapped;
    input [11:0] addr;
    begin
      is_mapped = addr_hit(addr, `IFSB_OFF_FLAGS0)  ||
                  addr_hit(addr, `IFSB_OFF_FLAGS1)  ||
                  addr_hit(addr, `IFSB_OFF_ENABLE0) ||
                  addr_hit(addr, `IFSB_OFF_ENABLE1) ||
                  addr_hit(addr, `IFSB_OFF_POLARITY);
    end
  endfunction

  // Byte-lane merge of a write into a register, spare bits dropped
  function [15:0] lane_merge;
    input [15:0] old_value;
    input [15:0] new_value;
    input [15:0] lanes;
    input [15:0] implemented;
    begin
      lane_merge = ((old_value & ~lanes) | (new_value & lanes)) &
                   implemented;
    end
  endfunction

  // Bus decode. The slave never stretches a transfer, so a write lands
  // at the one access edge and the master needs no wait logic here;
  // the cost is that every register must be ready in a single cycle.
  assign pready      = 1'b1;
  assign bus_access  = psel & penable;
  assign pslverr     = bus_access & ~is_mapped(paddr);
  assign wr_access   = bus_access & pwrite;
  assign rd_setup    = psel & ~penable & ~pwrite;
  assign wr_lanes    = lane_mask(pstrb);
  assign wr_flags_0  = wr_access & addr_hit(paddr, `IFSB_OFF_FLAGS0);
  assign wr_flags_1  = wr_access & addr_hit(paddr, `IFSB_OFF_FLAGS1);
  assign wr_enable_0 = wr_access & addr_hit(paddr, `IFSB_OFF_ENABLE0);
  assign wr_enable_1 = wr_access & addr_hit(paddr, `IFSB_OFF_ENABLE1);
  assign wr_polarity = wr_access & addr_hit(paddr, `IFSB_OFF_POLARITY);

  // Edge detect on the pins; polarity selects which edge counts.
  // Pins are taken as synchronous, so no synchroniser sits in front.
  generate
    for (g = 0; g < 3; g = g + 1) begin : pin_edge
      wire rise_seen;
      wire fall_seen;
      assign rise_seen   = ~ext_pin_prev[g] & ext_irq_pin[g];
      assign fall_seen   = ext_pin_prev[g] & ~ext_irq_pin[g];
      assign ext_edge[g] = ext_irq_polarity[g] ? fall_seen :
                                                 rise_seen;
    end
  endgenerate

  // Map each source pulse onto its flag position
  always @* begin
    hw_set_0 = 16'h0000;
    hw_set_0[`IFSB_B0_NVM]     = nvm_req;
    hw_set_0[`IFSB_B0_ADC]     = adc_done_req;
    hw_set_0[`IFSB_B0_UA_TX]   = uart_a_tx_req;
    hw_set_0[`IFSB_B0_UA_RX]   = uart_a_rx_req;
    hw_set_0[`IFSB_B0_SPI_EV]  = spi_a_event_req;
    hw_set_0[`IFSB_B0_SPI_FLT] = spi_a_fault_req;
    hw_set_0[`IFSB_B0_TMR_C]   = timer_c_req;
    hw_set_0[`IFSB_B0_TMR_B]   = timer_b_req;
    hw_set_0[`IFSB_B0_TMR_A]   = timer_a_req;
    hw_set_0[`IFSB_B0_OC_B]    = outcmp_b_req;
    hw_set_0[`IFSB_B0_OC_A]    = outcmp_a_req;
    hw_set_0[`IFSB_B0_IC_B]    = incap_b_req;
    hw_set_0[`IFSB_B0_IC_A]    = incap_a_req;
    hw_set_0[`IFSB_B0_EXT_A]   = ext_edge[0];
    hw_set_1 = 16'h0000;
    hw_set_1[`IFSB_B1_UB_TX]   = uart_b_tx_req;
    hw_set_1[`IFSB_B1_UB_RX]   = uart_b_rx_req;
    hw_set_1[`IFSB_B1_EXT_C]   = ext_edge[2];
    hw_set_1[`IFSB_B1_TMR_E]   = timer_e_req;
    hw_set_1[`IFSB_B1_TMR_D]   = timer_d_req;
    hw_set_1[`IFSB_B1_OC_C]    = outcmp_c_req;
    hw_set_1[`IFSB_B1_EXT_B]   = ext_edge[1];
    hw_set_1[`IFSB_B1_PIN_CHG] = pin_change_req;
    hw_set_1[`IFSB_B1_CMP]     = comparator_req;
    hw_set_1[`IFSB_B1_I2C_MST] = i2c_a_master_req;
    hw_set_1[`IFSB_B1_I2C_SLV] = i2c_a_slave_req;
  end

  // Software write first, hardware set OR-ed over it so a set is not lost
  always @* begin
    next_flags_0 = irq_flags_0;
    if (wr_flags_0) begin
      next_flags_0 = lane_merge(irq_flags_0, pwdata[15:0], wr_lanes,
                                `IFSB_MASK0);
    end
    next_flags_0 = (next_flags_0 | (hw_set_0 & hw_settable_0)) &
                   `IFSB_MASK0;
  end

  // Same merge for the second register
  always @* begin
    next_flags_1 = irq_flags_1;
    if (wr_flags_1) begin
      next_flags_1 = lane_merge(irq_flags_1, pwdata[15:0], wr_lanes,
                                `IFSB_MASK1);
    end
    next_flags_1 = (next_flags_1 | (hw_set_1 & hw_settable_1)) &
                   `IFSB_MASK1;
  end

  // Enable bits share the implemented masks of their flag registers
  always @* begin
    next_enable_0 = irq_enable_0;
    if (wr_enable_0) begin
      next_enable_0 = lane_merge(irq_enable_0, pwdata[15:0], wr_lanes,
                                 `IFSB_MASK0);
    end
  end

  // Second enable register
  always @* begin
    next_enable_1 = irq_enable_1;
    if (wr_enable_1) begin
      next_enable_1 = lane_merge(irq_enable_1, pwdata[15:0], wr_lanes,
                                 `IFSB_MASK1);
    end
  end

  // Polarity takes the whole word; only the three pin bits are kept
  always @* begin
    next_polarity = ext_irq_polarity;
    if (wr_polarity) begin
      next_polarity = pwdata[15:0] & `IFSB_POL_MASK;
    end
  end

  // Read data is picked in the setup cycle, so it already stands
  // when the master samples it at the access edge
  always @* begin
    case (paddr)
      `IFSB_OFF_FLAGS0:   next_prdata = {16'h0000, irq_flags_0};
      `IFSB_OFF_FLAGS1:   next_prdata = {16'h0000, irq_flags_1};
      `IFSB_OFF_ENABLE0:  next_prdata = {16'h0000, irq_enable_0};
      `IFSB_OFF_ENABLE1:  next_prdata = {16'h0000, irq_enable_1};
      `IFSB_OFF_POLARITY: next_prdata = {16'h0000, ext_irq_polarity};
      default:            next_prdata = 32'h00000000;
    endcase
  end

  // Flags latch the pulse on the edge after it arrives
  always @(posedge clk) begin
    if (srst) begin
      irq_flags_0 <= `IFSB_FLAGS_RST;
    end else begin
      irq_flags_0 <= next_flags_0;
    end
  end

  // Second flag register
  always @(posedge clk) begin
    if (srst) begin
      irq_flags_1 <= `IFSB_FLAGS_RST;
    end else begin
      irq_flags_1 <= next_flags_1;
    end
  end

  // Enables change only by software
  always @(posedge clk) begin
    if (srst) begin
      irq_enable_0 <= `IFSB_ENABLE_RST;
    end else begin
      irq_enable_0 <= next_enable_0;
    end
  end

  // Second enable register
  always @(posedge clk) begin
    if (srst) begin
      irq_enable_1 <= `IFSB_ENABLE_RST;
    end else begin
      irq_enable_1 <= next_enable_1;
    end
  end

  // Edge selection for the three pins
  always @(posedge clk) begin
    if (srst) begin
      ext_irq_polarity <= `IFSB_POL_RST;
    end else begin
      ext_irq_polarity <= next_polarity;
    end
  end

  // Pin history resets low, so a pin already high at release counts as
  // a rising edge; software clears that flag after setting polarity
  always @(posedge clk) begin
    if (srst) begin
      ext_pin_prev <= 3'h0;
    end else begin
      ext_pin_prev <= ext_irq_pin;
    end
  end

  // Read data holds until the next read setup
  always @(posedge clk) begin
    if (srst) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      prdata <= next_prdata;
    end
  end

  // Gating sits after the flag so disabled requests are still recorded
  always @(posedge clk) begin
    if (srst) begin
      cpu_req_0 <= 16'h0000;
    end else begin
      cpu_req_0 <= irq_flags_0 & irq_enable_0;
    end
  end

  // Second request group, one cycle behind its flags as well
  always @(posedge clk) begin
    if (srst) begin
      cpu_req_1 <= 16'h0000;
    end else begin
      cpu_req_1 <= irq_flags_1 & irq_enable_1;
    end
  end

endmodule // ifsb_flag_bank

//--- verification/ifsb_properties.sv
// Port checks of the flag bank
`timescale 1ns/10ps
`include "ifsb_defs.vh"
module ifsb_properties (
  // Bus
  input wire        clk,
  input wire        srst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  // Requests
  input wire        nvm_req,
  input wire        adc_done_req,
  input wire        uart_b_tx_req,
  input wire        i2c_a_slave_req,
  // Flags
  input wire [15:0] irq_flags_0,
  input wire [15:0] irq_flags_1,
  input wire [15:0] cpu_req_0
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  wire wr0 = psel && penable && pwrite && paddr == `IFSB_OFF_FLAGS0;
  a_nvm_set: assert property (nvm_req |=> irq_flags_0[15])
    else $error("nvm flag");
  a_adc_set: assert property (adc_done_req |=> irq_flags_0[13])
    else $error("adc flag");
  a_uart_b_set: assert property (uart_b_tx_req |=> irq_flags_1[15])
    else $error("uart flag");
  a_i2c_slv_set: assert property (i2c_a_slave_req |=> irq_flags_1[0])
    else $error("i2c flag");
  a_unimpl_zero: assert property (!(irq_flags_0 & ~`IFSB_MASK0))
    else $error("bank 0 spare bit");
  a_unimpl_one: assert property (!(irq_flags_1 & ~`IFSB_MASK1))
    else $error("bank 1 spare bit");
  a_reset_clear: assert property (disable iff (1'b0) srst |=>
    !irq_flags_0 && !irq_flags_1) else $error("reset flags");
  a_flag_hold: assert property
    (|($past(irq_flags_0) & ~irq_flags_0) |-> $past(wr0)) else $error("lost");
  a_cpu_gated: assert property
    (!(cpu_req_0 & ~$past(irq_flags_0))) else $error("cpu request");
endmodule // ifsb_properties

//--- verification/ifsb_src_model.sv
// Peripheral request sources
`timescale 1ns/10ps
module ifsb_src_model (
  // Clock
  input  wire        clk,
  // Command
  input  wire        go,
  input  wire [4:0]  idx,
  // Pulses
  output reg  [21:0] req
);
  initial req = 22'h000000;
  // One clock only, so one command is one event
  always @(posedge clk) req <= go ? 22'h000001 << idx : 22'h000000;
endmodule // ifsb_src_model

//--- verification/testbench.sv
// Flag bank bench
`timescale 1ns/10ps
`include "ifsb_defs.vh"
module testbench;
  reg         clk = 1'b0, srst = 1'b1, go = 1'b0, psel = 1'b0;
  reg         penable = 1'b0, pwrite = 1'b0, err;
  reg  [4:0]  idx = 5'h00, p;
  reg  [2:0]  pin = 3'h0;
  reg  [11:0] paddr = 12'h000, a;
  reg  [31:0] pwdata = 32'h0, rd;
  wire        pready, pslverr;
  wire [31:0] prdata;
  wire [21:0] req;
  wire [15:0] f0, f1, c0, c1;
  integer     n_mismatch = 0, n_checks = 0, cyc = 0, i;
  // Register select and bit of each source, last source first
  localparam [109:0] pos_tab = {5'h10, 5'h11, 5'h12, 5'h13, 5'h19, 5'h1c,
    5'h1b, 5'h1e, 5'h1f, 5'h05, 5'h01, 5'h06, 5'h02, 5'h08, 5'h07, 5'h03,
    5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0f};
  initial forever #20 clk = ~clk;
  ifsb_src_model ifsb_src_model_i (.clk(clk), .go(go), .idx(idx), .req(req));
  ifsb_flag_bank ifsb_flag_bank_i (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hf), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .nvm_req(req[0]), .adc_done_req(req[1]), .uart_a_tx_req(req[2]),
    .uart_a_rx_req(req[3]), .spi_a_event_req(req[4]),
    .spi_a_fault_req(req[5]), .timer_a_req(req[6]), .timer_b_req(req[7]),
    .timer_c_req(req[8]), .outcmp_a_req(req[9]), .outcmp_b_req(req[10]),
    .incap_a_req(req[11]), .incap_b_req(req[12]), .uart_b_tx_req(req[13]),
    .uart_b_rx_req(req[14]), .timer_d_req(req[15]), .timer_e_req(req[16]),
    .outcmp_c_req(req[17]), .pin_change_req(req[18]),
    .comparator_req(req[19]), .i2c_a_master_req(req[20]),
    .i2c_a_slave_req(req[21]), .ext_irq_pin(pin), .irq_flags_0(f0),
    .irq_flags_1(f1), .cpu_req_0(c0), .cpu_req_1(c1));
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (seen !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task apb(input w, input [11:0] ad, input [31:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= d;
      @(posedge clk) penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask
  task fire(input [4:0] k);
    begin
      go <= 1'b1;
      idx <= k;
      @(posedge clk) go <= 1'b0;
      @(posedge clk);
    end
  endtask
  task summarize;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 4000) begin
      n_mismatch = n_mismatch + 1;
      summarize;
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    for (i = 0; i < 22; i = i + 1) begin
      p = pos_tab[i*5 +: 5];
      a = {9'h000, p[4], 2'b00};
      apb(0, a, 0);
      chk(rd, 0);
      fire(i[4:0]);
      apb(0, a, 0);
      chk(rd, 32'h1 << p[3:0]);
      apb(1, a, 0);
    end
    for (i = 0; i < 2; i = i + 1) begin
      apb(1, i * 4, 32'hffffffff);
      apb(0, i * 4, 0);
      chk(rd, i ? `IFSB_MASK1 : `IFSB_MASK0);
      apb(1, i * 4, 0);
    end
    pin <= 3'b001;
    repeat (2) @(posedge clk);
    apb(0, `IFSB_OFF_FLAGS0, 0);
    chk(rd, 1);
    apb(1, `IFSB_OFF_POLARITY, 6);
    apb(1, `IFSB_OFF_FLAGS0, 0);
    pin <= 3'b111;
    repeat (2) @(posedge clk);
    apb(0, `IFSB_OFF_FLAGS1, 0);
    chk(rd, 0);
    pin <= 3'b001;
    repeat (2) @(posedge clk);
    apb(0, `IFSB_OFF_FLAGS1, 0);
    chk(rd, 32'h2010);
    apb(1, `IFSB_OFF_ENABLE0, 32'h8000);
    fire(0);
    fire(1);
    chk(c0, 32'h8000);
    apb(0, `IFSB_OFF_FLAGS0, 0);
    chk(rd, 32'ha000);
    apb(1, `IFSB_OFF_ENABLE1, 32'hffffffff);
    apb(0, `IFSB_OFF_ENABLE1, 0);
    chk(rd, `IFSB_MASK1);
    chk(c1, 32'h2010);
    apb(0, 12'h020, 0);
    chk({err, rd[30:0]}, 32'h80000000);
    pin <= 3'b000;
    @(posedge clk);
    srst <= 1'b1;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk({f1, f0}, 0);
    chk({c1, c0}, 0);
    fork
      fire(0);
      apb(1, `IFSB_OFF_FLAGS0, 0);
    join
    apb(0, `IFSB_OFF_FLAGS0, 0);
    chk(rd, 32'h8000);
    summarize;
  end
endmodule // testbench
bind ifsb_flag_bank ifsb_properties ifsb_properties_i (.clk(clk),
  .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .nvm_req(nvm_req), .adc_done_req(adc_done_req),
  .uart_b_tx_req(uart_b_tx_req), .i2c_a_slave_req(i2c_a_slave_req),
  .irq_flags_0(irq_flags_0), .irq_flags_1(irq_flags_1),
  .cpu_req_0(cpu_req_0));
